// ### src/pushbutton_reset_timer.sv
`timescale 1ns/1ps
module pushbutton_reset_timer #(
    parameter logic [31:0] HOLD_2S_CYCLES = pbr_pkg::HOLD_2S_CYC,
    parameter logic [31:0] HOLD_4S_CYCLES = pbr_pkg::HOLD_4S_CYC,
    parameter logic [31:0] HOLD_6S_CYCLES = pbr_pkg::HOLD_6S_CYC,
    parameter logic [31:0] PULSE_SHORT_CYCLES = pbr_pkg::PULSE_SHORT_CYC,
    parameter logic [31:0] PULSE_LONG_CYCLES = pbr_pkg::PULSE_LONG_CYC,
    parameter logic PULSE_LONG_OPTION = 1'b0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic first_button_input_n,
    input wire logic second_button_input_n,
    input wire logic delay_select_pin_in,
    output logic delay_select_pin_out,
    output logic delay_select_pin_oe,
    output logic reset_out_n_out,
    output logic reset_out_n_oe,
    output logic reset_out_high
);
    import pbr_pkg::*;

    typedef enum logic [2:0] {
        S_WAIT_CFG,
        S_IDLE,
        S_TIMING,
        S_PULSE,
        S_LOCKED
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic [31:0] cnt;
        logic pulse;
    } seq_t;

    seq_t st_ff;
    seq_t nxt_st;
    logic both_low;
    logic [31:0] hold_lim;
    logic [31:0] pulse_lim;

    cond_if cif ();

    // synchronised buttons and decoded select pin
    input_conditioner u_cond (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .first_button_input_n(first_button_input_n),
        .second_button_input_n(second_button_input_n),
        .delay_select_pin_in(delay_select_pin_in),
        .delay_select_pin_out(delay_select_pin_out),
        .delay_select_pin_oe(delay_select_pin_oe),
        .cif(cif)
    );

    // symmetric combine of both buttons, so order of pressing is irrelevant
    assign both_low = cif.b0_low && cif.b1_low;

    // hold delay limit from the select pin
    always_comb begin
        case (cif.sel)
            DLY_2S: hold_lim = HOLD_2S_CYCLES;
            DLY_4S: hold_lim = HOLD_4S_CYCLES;
            DLY_6S: hold_lim = HOLD_6S_CYCLES;
            default: hold_lim = HOLD_2S_CYCLES;
        endcase
    end

    // pulse length fixed at build time
    assign pulse_lim = PULSE_LONG_OPTION ? PULSE_LONG_CYCLES : PULSE_SHORT_CYCLES;

    // sequencer next state
    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            S_WAIT_CFG: begin
                if (cif.sel_valid) begin
                    nxt_st.state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (both_low) begin
                    nxt_st.state = S_TIMING;
                    nxt_st.cnt = CNT_RST;
                end
            end
            S_TIMING: begin
                if (!both_low) begin
                    nxt_st.state = S_IDLE;
                    nxt_st.cnt = CNT_RST;
                end else if (st_ff.cnt == hold_lim - 32'h1) begin
                    nxt_st.state = S_PULSE;
                    nxt_st.cnt = CNT_RST;
                    nxt_st.pulse = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 32'h1;
                end
            end
            S_PULSE: begin
                if (st_ff.cnt == pulse_lim - 32'h1) begin
                    nxt_st.pulse = 1'b0;
                    nxt_st.cnt = CNT_RST;
                    nxt_st.state = both_low ? S_LOCKED : S_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 32'h1;
                end
            end
            S_LOCKED: begin
                // stays quiet until a button is let go
                if (!both_low) begin
                    nxt_st.state = S_IDLE;
                end
            end
            default: begin
                nxt_st.state = S_IDLE;
                nxt_st.pulse = 1'b0;
                nxt_st.cnt = CNT_RST;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= '{state: S_WAIT_CFG, cnt: CNT_RST, pulse: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // open-drain low output pulls low during pulse, push-pull high is its inverse
    assign reset_out_n_out = 1'b0;
    assign reset_out_n_oe = st_ff.pulse;
    assign reset_out_high = st_ff.pulse;

    // pulse enters only from a full hold
    sequence seq_hold_done;
        st_ff.state == S_TIMING && both_low && st_ff.cnt == hold_lim - 32'h1;
    endsequence

    sequence seq_pulse_start;
        $rose(st_ff.pulse);
    endsequence

    property p_enter_after_hold;
        @(posedge sys_clk) disable iff (!nrst)
        seq_pulse_start |-> $past(st_ff.state) == S_TIMING &&
            $past(st_ff.cnt) == $past(hold_lim) - 32'h1;
    endproperty

    hold_select_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(cif.sel_valid) |=> (hold_lim == HOLD_2S_CYCLES && cif.sel == DLY_2S) ||
            (hold_lim == HOLD_4S_CYCLES && cif.sel == DLY_4S) ||
            (hold_lim == HOLD_6S_CYCLES && cif.sel == DLY_6S))
        else $error("hold limit does not match select");

    order_free_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        seq_pulse_start |-> $past(cif.b0_low) && $past(cif.b1_low))
        else $error("pulse without both buttons low");

    hold_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        seq_hold_done |=> st_ff.pulse && st_ff.state == S_PULSE)
        else $error("no pulse after full hold");

    no_repeat_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        st_ff.state == S_LOCKED && both_low |=> !st_ff.pulse)
        else $error("extra pulse while held");

    hold_length_a: assert property (p_enter_after_hold)
        else $error("pulse began before hold delay");

    pulse_length_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(st_ff.pulse) |-> $past(st_ff.cnt) == pulse_lim - 32'h1)
        else $error("pulse length wrong");

    out_inverse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reset_out_high == reset_out_n_oe && !reset_out_n_out &&
            reset_out_high == (st_ff.state == S_PULSE))
        else $error("outputs not complementary");

    abandon_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        st_ff.state == S_TIMING && !both_low |=> st_ff.state == S_IDLE && !st_ff.pulse)
        else $error("timing not abandoned on release");

    restart_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        st_ff.state == S_IDLE && both_low |=> st_ff.state == S_TIMING && st_ff.cnt == 32'h0)
        else $error("timing did not restart from zero");

    // pulse in progress and pulse on its last cycle
    sequence seq_pulse_mid;
        st_ff.state == S_PULSE && st_ff.cnt != pulse_lim - 32'h1;
    endsequence

    sequence seq_pulse_end;
        st_ff.state == S_PULSE && st_ff.cnt == pulse_lim - 32'h1;
    endsequence

    pulse_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        seq_pulse_mid |=> st_ff.state == S_PULSE && st_ff.pulse &&
            st_ff.cnt == $past(st_ff.cnt) + 32'h1)
        else $error("pulse cut short");

    pulse_end_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        seq_pulse_end |=> !st_ff.pulse && st_ff.cnt == 32'h0)
        else $error("pulse ran past its length");

    pulse_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        st_ff.state == S_PULSE |-> st_ff.cnt < pulse_lim)
        else $error("pulse counter out of range");

    timing_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        st_ff.state == S_TIMING |-> st_ff.cnt < hold_lim)
        else $error("hold counter out of range");

    lock_after_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        seq_pulse_end ##0 both_low |=> st_ff.state == S_LOCKED)
        else $error("no lockout while still held");

    idle_after_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        seq_pulse_end ##0 !both_low |=> st_ff.state == S_IDLE)
        else $error("no return to idle after pulse");

    cfg_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        st_ff.state == S_WAIT_CFG |-> !st_ff.pulse)
        else $error("pulse before select is known");
endmodule

// ### src/pbr_pkg.sv
package pbr_pkg;
    // clock rate in kHz, for time to cycle conversion
    localparam logic [63:0] CLK_KHZ = 64'd200000;

    // hold delay times in ms
    localparam logic [63:0] HOLD_2S_MS = 64'd2000;
    localparam logic [63:0] HOLD_4S_MS = 64'd4000;
    localparam logic [63:0] HOLD_6S_MS = 64'd6000;

    // pulse duration options in ms (least values)
    localparam logic [63:0] PULSE_SHORT_MS = 64'd140;
    localparam logic [63:0] PULSE_LONG_MS = 64'd240;

    // derived cycle counts (exact at this clock rate)
    localparam logic [31:0] HOLD_2S_CYC = 32'(HOLD_2S_MS * CLK_KHZ);
    localparam logic [31:0] HOLD_4S_CYC = 32'(HOLD_4S_MS * CLK_KHZ);
    localparam logic [31:0] HOLD_6S_CYC = 32'(HOLD_6S_MS * CLK_KHZ);
    localparam logic [31:0] PULSE_SHORT_CYC = 32'(PULSE_SHORT_MS * CLK_KHZ);
    localparam logic [31:0] PULSE_LONG_CYC = 32'(PULSE_LONG_MS * CLK_KHZ);

    // probe phase length for the three-state select pin
    localparam logic [7:0] PROBE_CYC = 8'h10;

    // value of all counters after reset
    localparam logic [31:0] CNT_RST = 32'h0000_0000;

    // decoded delay selection
    typedef enum logic [1:0] {
        DLY_2S,
        DLY_4S,
        DLY_6S
    } delay_sel_t;
endpackage

// ### src/cond_if.sv
`timescale 1ns/1ps
// cleaned inputs from the conditioner to the sequencer
interface cond_if;
    import pbr_pkg::*;
    logic b0_low;
    logic b1_low;
    delay_sel_t sel;
    logic sel_valid;
    modport src (output b0_low, output b1_low, output sel, output sel_valid);
    modport snk (input b0_low, input b1_low, input sel, input sel_valid);
endinterface

// ### src/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic first_button_input_n,
    input wire logic second_button_input_n,
    input wire logic delay_select_pin_in,
    output logic delay_select_pin_out,
    output logic delay_select_pin_oe,
    cond_if.src cif
);
    import pbr_pkg::*;

    typedef enum logic [2:0] {
        P_DRIVE_HI,
        P_FLOAT_HI,
        P_DRIVE_LO,
        P_FLOAT_LO,
        P_DONE
    } probe_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] clean;
        probe_t phase;
        logic [7:0] cnt;
        logic samp_hi;
        delay_sel_t sel;
        logic sel_valid;
    } cond_state_t;

    cond_state_t st_ff;
    cond_state_t nxt_st;

    // three-stage sync, debounced once stages two and three agree; probe of the select pin
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {delay_select_pin_in, second_button_input_n, first_button_input_n};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.clean[i] = st_ff.s2[i];
            end
        end
        // float detection: a floating pin keeps the level last driven on it
        if (st_ff.phase != P_DONE) begin
            if (st_ff.cnt == PROBE_CYC) begin
                nxt_st.cnt = 8'h00;
                case (st_ff.phase)
                    P_DRIVE_HI: nxt_st.phase = P_FLOAT_HI;
                    P_FLOAT_HI: begin
                        nxt_st.samp_hi = st_ff.clean[2];
                        nxt_st.phase = P_DRIVE_LO;
                    end
                    P_DRIVE_LO: nxt_st.phase = P_FLOAT_LO;
                    P_FLOAT_LO: begin
                        nxt_st.phase = P_DONE;
                        nxt_st.sel_valid = 1'b1;
                        if (st_ff.samp_hi && !st_ff.clean[2]) begin
                            nxt_st.sel = DLY_2S;
                        end else if (!st_ff.samp_hi && !st_ff.clean[2]) begin
                            nxt_st.sel = DLY_4S;
                        end else if (st_ff.samp_hi && st_ff.clean[2]) begin
                            nxt_st.sel = DLY_6S;
                        end else begin
                            nxt_st.sel = DLY_2S;
                        end
                    end
                    default: nxt_st.phase = P_DONE;
                endcase
            end else begin
                nxt_st.cnt = st_ff.cnt + 8'h01;
            end
        end
    end

    // state register with synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, clean: 3'h7, phase: P_DRIVE_HI,
                       cnt: 8'h00, samp_hi: 1'b0, sel: DLY_2S,
                       sel_valid: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pin driven only in the drive phases
    assign delay_select_pin_out = (st_ff.phase == P_DRIVE_HI);
    assign delay_select_pin_oe = (st_ff.phase == P_DRIVE_HI) || (st_ff.phase == P_DRIVE_LO);
    assign cif.b0_low = !st_ff.clean[0];
    assign cif.b1_low = !st_ff.clean[1];
    assign cif.sel = st_ff.sel;
    assign cif.sel_valid = st_ff.sel_valid;
endmodule

// ### bench/pbr_partner.sv
`timescale 1ns/1ps
// select pin strap and pulled-up reset line, as the board around the block
module pbr_partner (
    input wire logic sys_clk,
    input wire logic [1:0] strap_mode,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic rst_n_out,
    input wire logic rst_n_oe,
    output logic pin_in,
    output logic rst_n_level
);
    logic held_ff;
    // an open pin keeps the charge of the last drive
    always_ff @(posedge sys_clk) begin
        if (pin_oe) begin
            held_ff <= pin_out;
        end
    end
    // strap mode 0 open, 1 ground, 2 supply, 3 open pin that flips once let go
    always_comb begin
        case (strap_mode)
            2'h1: pin_in = 1'b0;
            2'h2: pin_in = 1'b1;
            2'h3: pin_in = pin_oe ? pin_out : !held_ff;
            default: pin_in = pin_oe ? pin_out : held_ff;
        endcase
    end
    // open-drain line with a pull-up to the host supply
    assign rst_n_level = rst_n_oe ? rst_n_out : 1'b1;
endmodule

// ### bench/pushbutton_reset_timer_bench.sv
`timescale 1ns/1ps
module pushbutton_reset_timer_bench;
    import pbr_pkg::*;
    localparam int PULSE = 10;
    typedef struct {logic [1:0] mode; logic lead; int hold;} row_t;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic b0_n = 1'b1;
    logic b1_n = 1'b1;
    logic [1:0] strap_mode = 2'h0;
    logic pin_in, pin_out, pin_oe, rst_out, rst_oe, rst_high, rst_level, prev_high;
    int errors = 0;
    int total_checks = 0;
    int pulse_cnt = 0;
    int n, w, base;
    // strap, which button goes first, expected hold in cycles
    row_t rows [7] = '{'{2'h0, 1'b0, 40}, '{2'h1, 1'b1, 80}, '{2'h2, 1'b0, 120},
        '{2'h0, 1'b1, 40}, '{2'h1, 1'b0, 80}, '{2'h2, 1'b1, 120}, '{2'h3, 1'b0, 40}};

    pushbutton_reset_timer #(
        .HOLD_2S_CYCLES(32'd40),
        .HOLD_4S_CYCLES(32'd80),
        .HOLD_6S_CYCLES(32'd120),
        .PULSE_SHORT_CYCLES(32'd10),
        .PULSE_LONG_CYCLES(32'd20)
    ) i_dut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .first_button_input_n(b0_n),
        .second_button_input_n(b1_n),
        .delay_select_pin_in(pin_in),
        .delay_select_pin_out(pin_out),
        .delay_select_pin_oe(pin_oe),
        .reset_out_n_out(rst_out),
        .reset_out_n_oe(rst_oe),
        .reset_out_high(rst_high)
    );

    pbr_partner i_partner (
        .sys_clk(sys_clk),
        .strap_mode(strap_mode),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .rst_n_out(rst_out),
        .rst_n_oe(rst_oe),
        .pin_in(pin_in),
        .rst_n_level(rst_level)
    );

    // clock at 200 MHz
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // inputs change a fixed 1 ns after the rising edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    // reset for 5 cycles, reset outputs quiet and probe driving high, then let the probe finish
    task automatic do_reset();
        nrst = 1'b0;
        repeat (5) tick();
        check({rst_high, rst_oe, pin_oe, pin_out}, 32'h3);
        nrst = 1'b1;
        repeat (100) tick();
    endtask

    // cycles until the pulse starts, bounded
    task automatic wait_rise(output int cnt);
        cnt = 0;
        while (rst_high !== 1'b1 && cnt < 400) begin
            tick();
            cnt++;
        end
    endtask

    // outputs stay complementary, pulses are counted by their rising edge
    always @(posedge sys_clk) begin
        prev_high <= rst_high;
        if (nrst === 1'b1) begin
            check(rst_oe, rst_high);
            check(rst_level, !rst_high);
            if (rst_high === 1'b1 && prev_high === 1'b0) begin
                pulse_cnt++;
            end
        end
    end

    // watchdog well beyond the length of all tests
    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    initial begin
        // table of straps and press orders
        foreach (rows[i]) begin
            strap_mode = rows[i].mode;
            do_reset();
            if (rows[i].lead) b1_n = 1'b0;
            else b0_n = 1'b0;
            repeat (3) tick();
            if (rows[i].lead) b0_n = 1'b0;
            else b1_n = 1'b0;
            base = pulse_cnt;
            wait_rise(n);
            check(n >= rows[i].hold && n <= rows[i].hold + 8, 1);
            w = 0;
            while (rst_high === 1'b1 && w < 100) begin
                tick();
                w++;
            end
            check(w, PULSE);
            repeat (300) tick();
            check(pulse_cnt - base, 1);
            b0_n = 1'b1;
            b1_n = 1'b1;
            repeat (10) tick();
            $display("row %0d done", i);
        end
        // early release abandons, next press times from zero
        strap_mode = 2'h0;
        do_reset();
        base = pulse_cnt;
        b0_n = 1'b0;
        b1_n = 1'b0;
        repeat (30) tick();
        b0_n = 1'b1;
        repeat (30) tick();
        check(pulse_cnt - base, 0);
        b0_n = 1'b0;
        wait_rise(n);
        check(n >= 40 && n <= 48, 1);
        // letting go at once does not shorten the pulse
        b0_n = 1'b1;
        b1_n = 1'b1;
        w = 0;
        while (rst_high === 1'b1 && w < 100) begin
            tick();
            w++;
        end
        check(w, PULSE);
        repeat (10) tick();
        check(pulse_cnt - base, 1);
        $display("early release done");
        // reset in mid-pulse quiets the outputs and no pulse follows
        base = pulse_cnt;
        b0_n = 1'b0;
        b1_n = 1'b0;
        wait_rise(n);
        check(n >= 40 && n <= 48, 1);
        tick();
        b0_n = 1'b1;
        b1_n = 1'b1;
        do_reset();
        check(rst_high, 1'b0);
        check(pulse_cnt - base, 1);
        $display("reset in pulse done");
        end_of_test();
    end
endmodule
